// ==== hw/bsp_pkg.sv ====
// package for the boot select and power mode block
package bsp_pkg;
  // initial program counter values
  localparam logic [31:0] BSP_PC_SCRATCH = 32'hD400_0000;
  localparam logic [31:0] BSP_PC_ROM = 32'hDFFF_FFFC;
  localparam logic [31:0] BSP_PC_EXT = 32'hA000_0000;
  localparam logic [31:0] BSP_PC_EMU = 32'hDE00_0000;
  localparam logic [31:0] BSP_PC_LOADER = 32'hC000_0004;
  localparam logic [31:0] BSP_PC_NONE = 32'h0000_0000;
  localparam logic [2:0] BSP_CFG_SCRATCH = 3'h0;
  localparam logic [2:0] BSP_CFG_EXT = 3'h4;
  // register byte offsets
  localparam logic [7:0] BSP_OFF_BOOT = 8'h00;
  localparam logic [7:0] BSP_OFF_PC = 8'h04;
  localparam logic [7:0] BSP_OFF_MODE_REQ = 8'h08;
  localparam logic [7:0] BSP_OFF_MODE_STAT = 8'h0C;
  localparam logic [7:0] BSP_OFF_SLEEP_EN = 8'h10;
  localparam logic [7:0] BSP_OFF_CLK_EN = 8'h14;
  localparam logic [7:0] BSP_OFF_WAKE_EN = 8'h18;
  // reset values
  localparam logic [31:0] BSP_RST_CLK_EN = 32'hFFFF_FFFF;
  localparam logic [31:0] BSP_RST_SLEEP_EN = 32'h0000_0000;
  localparam logic [31:0] BSP_RST_WAKE_EN = 32'h0000_0000;
  // shutdown sequence length in cycles
  localparam logic [3:0] BSP_SHUT_CYCLES = 4'h4;
  localparam logic [1:0] BSP_RESP_OKAY = 2'h0;
  localparam logic [1:0] BSP_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0]
  {
    BSP_BOOT_SCRATCH = 3'b000,
    BSP_BOOT_ROM = 3'b001,
    BSP_BOOT_EXT_SLAVE = 3'b010,
    BSP_BOOT_EXT_MASTER = 3'b011,
    BSP_BOOT_TRISTATE = 3'b100,
    BSP_BOOT_HALT_SLAVE = 3'b101,
    BSP_BOOT_HALT_MASTER = 3'b110,
    BSP_BOOT_HALT_OFF = 3'b111
  } bsp_boot_t;

  typedef enum logic [2:0]
  {
    BSP_PM_RUN = 3'b000,
    BSP_PM_IDLE = 3'b001,
    BSP_PM_SLEEP_SHUT = 3'b010,
    BSP_PM_SLEEP = 3'b011,
    BSP_PM_DEEP_SHUT = 3'b100,
    BSP_PM_DEEP = 3'b101
  } bsp_pm_t;

  // software mode request codes
  localparam logic [1:0] BSP_REQ_IDLE = 2'h1;
  localparam logic [1:0] BSP_REQ_SLEEP = 2'h2;
  localparam logic [1:0] BSP_REQ_DEEP = 2'h3;
endpackage

// ==== hw/bsp_top.sv ====
// boot action decoder and power mode state machine with an axi4-lite register slave
// Notes on behaviour
// - both straps high, cfg low 000: start scratchpad D4000000, only after software reset
// - both straps high, cfg low not 000/100: start boot rom DFFFFFFC
// - both straps high, cfg3 low, cfg low 100: external memory A0000000, bus slave
// - both straps high, cfg3 high, cfg low 100: external memory, bus master
// - debug high, break low: ignore cfg, tri-state pins, enter deep sleep
// - debug low, break high, cfg 0100: halt, external bus as slave
// - debug low, break high, cfg 1100: halt, external bus as master
// - debug low, break high, other cfg: halt, external bus disabled
// - both straps low: ignore cfg, start emulator space DE000000
// - run mode: clocks and peripherals enabled as software configured
// - idle on request: cpu clock stopped, peripherals clocked, memory reachable
// - idle wakes on reset, watchdog, nmi falling edge or enabled interrupt
// - sleep: clock only to peripherals set to run in sleep
// - sleep wakes on running peripheral interrupt, watchdog, nmi fall, reset
// - sleep entry passes through an orderly shutdown sequence
// - deep sleep entry passes shutdown then stops system clock fully
// - deep sleep leaves only on an external signal from outside
// - idle units gated off automatically, re-enabled when next needed
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
module bsp_top
  import bsp_pkg::*;
#(
  parameter int NPER = 8
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic sw_reset,
  input wire logic debug_enable_strap,
  input wire logic break_input_strap,
  input wire logic [3:0] boot_cfg,
  input wire logic nmi_n,
  input wire logic watchdog_event,
  input wire logic ext_wake,
  input wire logic [NPER-1:0] periph_irq,
  input wire logic [NPER-1:0] periph_busy,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] boot_pc,
  output logic cpu_run,
  output logic ext_bus_enable,
  output logic ext_bus_master,
  output logic pins_tristate,
  output logic cpu_clk_en,
  output logic [NPER-1:0] periph_clk_en,
  output logic sys_clk_en,
  output logic [2:0] power_mode
);

  typedef struct packed
  {
    logic seen_rel;
    logic sw_boot;
    bsp_boot_t boot;
    logic [31:0] pc;
    bsp_pm_t pm;
    logic [3:0] shut_cnt;
    logic nmi_prev;
    logic [NPER-1:0] sleep_en;
    logic [NPER-1:0] clk_en;
    logic [NPER-1:0] wake_en;
    logic [NPER-1:0] pclk;
    logic cpu_clk;
    logic sys_clk;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bsp_state_t;

  bsp_state_t st_reg;
  bsp_state_t st_next;

  // ==========================================================
  // boot decode
  function automatic bsp_boot_t bsp_decode(input logic dbg, input logic brk, input logic [3:0] cfg);
    bsp_boot_t b;
    b = BSP_BOOT_HALT_OFF;
    if (dbg && brk)
    begin
      if (cfg[2:0] == BSP_CFG_SCRATCH)
        b = BSP_BOOT_SCRATCH;
      else if (cfg[2:0] == BSP_CFG_EXT)
        b = cfg[3] ? BSP_BOOT_EXT_MASTER : BSP_BOOT_EXT_SLAVE;
      else
        b = BSP_BOOT_ROM;
    end
    else if (dbg && !brk)
      b = BSP_BOOT_TRISTATE;
    else if (!dbg && brk)
    begin
      if (cfg[2:0] == BSP_CFG_EXT)
        b = cfg[3] ? BSP_BOOT_HALT_MASTER : BSP_BOOT_HALT_SLAVE;
      else
        b = BSP_BOOT_HALT_OFF;
    end
    else
      b = BSP_BOOT_HALT_OFF;
    return b;
  endfunction

  function automatic logic [31:0] bsp_pc_of(input bsp_boot_t b, input logic dbg, input logic brk);
    logic [31:0] p;
    p = BSP_PC_NONE;
    if (!dbg && !brk)
      p = BSP_PC_EMU;
    else
      unique case (b)
        BSP_BOOT_SCRATCH: p = BSP_PC_SCRATCH;
        BSP_BOOT_ROM: p = BSP_PC_ROM;
        BSP_BOOT_EXT_SLAVE: p = BSP_PC_EXT;
        BSP_BOOT_EXT_MASTER: p = BSP_PC_EXT;
        default: p = BSP_PC_NONE;
      endcase
    return p;
  endfunction

  function automatic logic [31:0] bsp_fit(input logic [NPER-1:0] v);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[NPER-1:0] = v;
    return r;
  endfunction

  // ==========================================================
  // next state
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic rd_take;
  logic nmi_fall;
  logic [NPER-1:0] wdat;
  logic emu;
  bsp_boot_t dec;

  always_comb
  begin
    st_next = st_reg;
    aw_take = s_axi_awvalid && !st_reg.aw_held;
    w_take = s_axi_wvalid && !st_reg.w_held;
    wr_fire = 1'b0;
    rd_take = s_axi_arvalid && !st_reg.rvalid;
    nmi_fall = st_reg.nmi_prev && !nmi_n;
    wdat = st_reg.w_data[NPER-1:0];
    emu = !debug_enable_strap && !break_input_strap;
    dec = bsp_decode(debug_enable_strap, break_input_strap, boot_cfg);
    st_next.nmi_prev = nmi_n;

    // straps caught once on the first clocked cycle after release
    if (!st_reg.seen_rel)
    begin
      st_next.seen_rel = 1'b1;
      st_next.boot = dec;
      st_next.pc = bsp_pc_of(dec, debug_enable_strap, break_input_strap);
      // a power-on start cannot use scratchpad, it is not yet loaded
      if (dec == BSP_BOOT_SCRATCH && !st_reg.sw_boot && !emu)
      begin
        st_next.boot = BSP_BOOT_ROM;
        st_next.pc = BSP_PC_ROM;
      end
      if (dec == BSP_BOOT_TRISTATE)
        st_next.pm = BSP_PM_DEEP_SHUT;
    end

    // bus: address and data in either order
    if (aw_take)
    begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr[7:0];
    end
    if (w_take)
    begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid)
    begin
      wr_fire = 1'b1;
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = BSP_RESP_OKAY;
      unique case (st_reg.aw_addr)
        BSP_OFF_MODE_REQ:
        begin
          // requests outside run are dropped
          if (st_reg.pm == BSP_PM_RUN && st_reg.w_strb[0])
            unique case (st_reg.w_data[1:0])
              BSP_REQ_IDLE: st_next.pm = BSP_PM_IDLE;
              BSP_REQ_SLEEP: st_next.pm = BSP_PM_SLEEP_SHUT;
              BSP_REQ_DEEP: st_next.pm = BSP_PM_DEEP_SHUT;
              default: st_next.pm = BSP_PM_RUN;
            endcase
        end
        BSP_OFF_SLEEP_EN: st_next.sleep_en = wdat;
        BSP_OFF_CLK_EN: st_next.clk_en = wdat;
        BSP_OFF_WAKE_EN: st_next.wake_en = wdat;
        BSP_OFF_BOOT: st_next.bresp = BSP_RESP_OKAY;
        BSP_OFF_PC: st_next.bresp = BSP_RESP_OKAY;
        BSP_OFF_MODE_STAT: st_next.bresp = BSP_RESP_OKAY;
        default: st_next.bresp = BSP_RESP_SLVERR;
      endcase
    end
    if (st_reg.bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;

    if (rd_take)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp = BSP_RESP_OKAY;
      unique case (s_axi_araddr[7:0])
        BSP_OFF_BOOT: st_next.rdata = {29'h0000_0000, st_reg.boot};
        BSP_OFF_PC: st_next.rdata = st_reg.pc;
        BSP_OFF_MODE_STAT: st_next.rdata = {29'h0000_0000, st_reg.pm};
        BSP_OFF_MODE_REQ: st_next.rdata = 32'h0000_0000;
        BSP_OFF_SLEEP_EN: st_next.rdata = bsp_fit(st_reg.sleep_en);
        BSP_OFF_CLK_EN: st_next.rdata = bsp_fit(st_reg.clk_en);
        BSP_OFF_WAKE_EN: st_next.rdata = bsp_fit(st_reg.wake_en);
        default:
        begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = BSP_RESP_SLVERR;
        end
      endcase
    end
    else if (st_reg.rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;

    // ========================================================
    // power mode state machine
    unique case (st_reg.pm)
      BSP_PM_RUN:
        st_next.shut_cnt = 4'h0;
      BSP_PM_IDLE:
        if (watchdog_event || nmi_fall || |(periph_irq & st_reg.wake_en))
          st_next.pm = BSP_PM_RUN;
      BSP_PM_SLEEP_SHUT, BSP_PM_DEEP_SHUT:
      begin
        // cpu clock drops on entry, then at count 3 the peripheral clocks drop, in sleep entry only those not set for sleep
        st_next.shut_cnt = st_reg.shut_cnt + 4'h1;
        if (st_reg.shut_cnt == BSP_SHUT_CYCLES - 4'h1)
          st_next.pm = (st_reg.pm == BSP_PM_SLEEP_SHUT) ? BSP_PM_SLEEP : BSP_PM_DEEP;
      end
      BSP_PM_SLEEP:
        if (watchdog_event || nmi_fall || |(periph_irq & st_reg.sleep_en))
          st_next.pm = BSP_PM_RUN;
      BSP_PM_DEEP:
        if (ext_wake && st_reg.boot != BSP_BOOT_TRISTATE)
          st_next.pm = BSP_PM_RUN;
      default:
        st_next.pm = BSP_PM_RUN;
    endcase

    // clock gating per mode
    st_next.cpu_clk = (st_next.pm == BSP_PM_RUN);
    st_next.sys_clk = (st_next.pm != BSP_PM_DEEP);
    for (int i = 0; i < NPER; i++)
    begin
      unique case (st_next.pm)
        BSP_PM_RUN, BSP_PM_IDLE:
          // automatic gating: enabled only while busy or interrupting
          st_next.pclk[i] = st_next.clk_en[i] && (periph_busy[i] || periph_irq[i]);
        BSP_PM_SLEEP:
          st_next.pclk[i] = st_next.sleep_en[i] && (periph_busy[i] || periph_irq[i]);
        BSP_PM_SLEEP_SHUT:
          st_next.pclk[i] = st_reg.pclk[i] && (st_next.sleep_en[i] || (st_reg.shut_cnt < 4'h2));
        default:
          st_next.pclk[i] = st_reg.pclk[i] && (st_reg.shut_cnt < 4'h2);
      endcase
    end
    if (st_reg.pm == BSP_PM_SLEEP_SHUT || st_reg.pm == BSP_PM_DEEP_SHUT)
      st_next.cpu_clk = 1'b0;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      st_reg <= '0;
      st_reg.sw_boot <= 1'b0;
      st_reg.boot <= BSP_BOOT_HALT_OFF;
      st_reg.pm <= BSP_PM_RUN;
      st_reg.nmi_prev <= 1'b1;
      st_reg.clk_en <= BSP_RST_CLK_EN[NPER-1:0];
      st_reg.sleep_en <= BSP_RST_SLEEP_EN[NPER-1:0];
      st_reg.wake_en <= BSP_RST_WAKE_EN[NPER-1:0];
      st_reg.sys_clk <= 1'b1;
    end
    else if (sw_reset)
    begin
      // software reset re-samples the straps and allows scratchpad start
      st_reg <= '0;
      st_reg.sw_boot <= 1'b1;
      st_reg.boot <= BSP_BOOT_HALT_OFF;
      st_reg.pm <= BSP_PM_RUN;
      st_reg.nmi_prev <= 1'b1;
      st_reg.clk_en <= BSP_RST_CLK_EN[NPER-1:0];
      st_reg.sleep_en <= BSP_RST_SLEEP_EN[NPER-1:0];
      st_reg.wake_en <= BSP_RST_WAKE_EN[NPER-1:0];
      st_reg.sys_clk <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // ==========================================================
  // outputs
  assign s_axi_awready = !st_reg.aw_held;
  assign s_axi_wready = !st_reg.w_held;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign boot_pc = st_reg.pc;
  assign cpu_run = st_reg.seen_rel && (st_reg.boot inside {BSP_BOOT_SCRATCH, BSP_BOOT_ROM,
    BSP_BOOT_EXT_SLAVE, BSP_BOOT_EXT_MASTER} || st_reg.pc == BSP_PC_EMU);
  assign ext_bus_enable = st_reg.boot inside {BSP_BOOT_EXT_SLAVE, BSP_BOOT_EXT_MASTER,
    BSP_BOOT_HALT_SLAVE, BSP_BOOT_HALT_MASTER};
  assign ext_bus_master = st_reg.boot inside {BSP_BOOT_EXT_MASTER, BSP_BOOT_HALT_MASTER};
  assign pins_tristate = (st_reg.boot == BSP_BOOT_TRISTATE);
  assign cpu_clk_en = st_reg.cpu_clk && cpu_run;
  assign periph_clk_en = st_reg.pclk;
  assign sys_clk_en = st_reg.sys_clk;
  assign power_mode = st_reg.pm;

  // ==========================================================
  // checks
  sequence s_shut_sleep;
    st_reg.pm == BSP_PM_SLEEP_SHUT [*4];
  endsequence

  chk_sleep_shutdown: assert property (@(posedge clock) disable iff (!reset_n || sw_reset)
    (st_reg.pm == BSP_PM_RUN && st_next.pm == BSP_PM_SLEEP_SHUT) |=> s_shut_sleep ##1 st_reg.pm == BSP_PM_SLEEP)
    else $error("sleep entry skipped shutdown");
  chk_deep_clock_off: assert property (@(posedge clock) disable iff (!reset_n || sw_reset)
    st_reg.pm == BSP_PM_DEEP |-> !sys_clk_en)
    else $error("system clock running in deep sleep");
  chk_deep_no_wake: assert property (@(posedge clock) disable iff (!reset_n || sw_reset)
    (st_reg.pm == BSP_PM_DEEP && !ext_wake) |=> st_reg.pm == BSP_PM_DEEP)
    else $error("deep sleep left without external wake");
  chk_idle_nmi_wake: assert property (@(posedge clock) disable iff (!reset_n || sw_reset)
    (st_reg.pm == BSP_PM_IDLE && $fell(nmi_n)) |=> st_reg.pm == BSP_PM_RUN)
    else $error("idle did not wake on nmi");
  chk_idle_cpu_stop: assert property (@(posedge clock) disable iff (!reset_n || sw_reset)
    $past(st_reg.pm) == BSP_PM_IDLE && st_reg.pm == BSP_PM_IDLE |-> !cpu_clk_en)
    else $error("cpu clock running in idle");
  chk_boot_hold: assert property (@(posedge clock) disable iff (!reset_n || sw_reset)
    st_reg.seen_rel |=> $stable(boot_pc) && $stable(st_reg.boot))
    else $error("boot action changed");
  chk_mode_gate: assert property (@(posedge clock) disable iff (!reset_n || sw_reset)
    (wr_fire && st_reg.aw_addr == BSP_OFF_MODE_REQ && st_reg.pm inside {BSP_PM_IDLE, BSP_PM_SLEEP})
    |=> (st_reg.pm == $past(st_reg.pm) || st_reg.pm == BSP_PM_RUN))
    else $error("mode request taken outside run");
  chk_emu_pc: assert property (@(posedge clock) disable iff (!reset_n || sw_reset)
    (!st_reg.seen_rel && !debug_enable_strap && !break_input_strap) |=> boot_pc == BSP_PC_EMU)
    else $error("emulator start address wrong");
  chk_tristate_deep: assert property (@(posedge clock) disable iff (!reset_n || sw_reset)
    (!st_reg.seen_rel && debug_enable_strap && !break_input_strap) |=> ##4 st_reg.pm == BSP_PM_DEEP && pins_tristate)
    else $error("tri-state boot did not reach deep sleep");
  chk_sleep_gate: assert property (@(posedge clock) disable iff (!reset_n || sw_reset)
    st_reg.pm == BSP_PM_SLEEP |-> (periph_clk_en & ~st_reg.sleep_en) == '0)
    else $error("clock reaches peripheral not set for sleep");

endmodule // bsp_top

// ==== dv/bsp_board_model.sv ====
// board side model: nmi pin and external wake line driven on request
`timescale 1ns/10ps
module bsp_board_model
(
  input wire logic clock,
  input wire logic nmi_req,
  input wire logic wake_req,
  output logic nmi_n,
  output logic ext_wake
);
  // ==========================================
  // pulse stretchers
  logic [1:0] nmi_cnt_reg = 2'h0;
  logic [1:0] wake_cnt_reg = 2'h0;

  always_ff @(posedge clock)
  begin
    nmi_cnt_reg <= nmi_req ? 2'h2 : ((nmi_cnt_reg != 2'h0) ? nmi_cnt_reg - 2'h1 : 2'h0);
    wake_cnt_reg <= wake_req ? 2'h2 : ((wake_cnt_reg != 2'h0) ? wake_cnt_reg - 2'h1 : 2'h0);
  end

  // two-cycle low pulse so the falling edge is seen edge to edge
  assign nmi_n = (nmi_cnt_reg == 2'h0);
  assign ext_wake = (wake_cnt_reg != 2'h0);
endmodule // bsp_board_model

// ==== dv/test_boot_select_power_modes.sv ====
// self-checking bench for the boot select and power mode block
`timescale 1ns/10ps
module test_boot_select_power_modes;
  import bsp_pkg::*;
  localparam int NPER = 8;
  // flags {cpu_run, bus en, bus master, tristate} per boot code, code 0 in the low nibble
  localparam logic [31:0] FLG_TAB = 32'h0641_EC88;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic sw_reset = 1'b0;
  logic debug_enable_strap = 1'b1;
  logic break_input_strap = 1'b1;
  logic [3:0] boot_cfg = 4'h1;
  logic nmi_n, ext_wake, nmi_req = 1'b0, wake_req = 1'b0;
  logic watchdog_event = 1'b0;
  logic [NPER-1:0] periph_irq = 8'h00;
  logic [NPER-1:0] periph_busy = 8'h00;
  logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000, s_axi_araddr = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  // responses are always accepted at once
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, boot_pc;
  logic cpu_run, ext_bus_enable, ext_bus_master, pins_tristate, cpu_clk_en, sys_clk_en;
  logic [NPER-1:0] periph_clk_en;
  logic [2:0] power_mode;
  logic [31:0] seed = 32'h5655_adf0;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;

  bsp_top #(.NPER(NPER)) i_bsp_top (.clock, .reset_n, .sw_reset, .debug_enable_strap, .break_input_strap,
    .boot_cfg, .nmi_n, .watchdog_event, .ext_wake, .periph_irq, .periph_busy, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .boot_pc, .cpu_run, .ext_bus_enable, .ext_bus_master, .pins_tristate, .cpu_clk_en,
    .periph_clk_en, .sys_clk_en, .power_mode);
  bsp_board_model i_bsp_board_model (.clock, .nmi_req, .wake_req, .nmi_n, .ext_wake);

  always #12.5 clock = ~clock;

  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // returns {boot code, initial pc}
  function automatic logic [34:0] exp_boot(input logic d, input logic b, input logic [3:0] c, input logic sw);
    if (d && b)
    begin
      if (c[2:0] == BSP_CFG_SCRATCH && sw) return {3'h0, BSP_PC_SCRATCH};
      if (c[2:0] == BSP_CFG_EXT) return {(c[3] ? 3'h3 : 3'h2), BSP_PC_EXT};
      return {3'h1, BSP_PC_ROM};
    end
    if (d) return {3'h4, BSP_PC_NONE};
    if (b) return {((c == 4'h4) ? 3'h5 : ((c == 4'hC) ? 3'h6 : 3'h7)), BSP_PC_NONE};
    return {3'h7, BSP_PC_EMU};
  endfunction

  task automatic summarize();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk(32'(got), 32'(exp));
  endtask

  task automatic do_reset(input logic sw, input int n);
    if (sw) sw_reset <= 1'b1;
    else reset_n <= 1'b0;
    repeat (n) @(posedge clock);
    sw_reset <= 1'b0;
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= 32'(a);
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= 32'(a);
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic wait_mode(input logic [2:0] m, output int n);
    n = 0;
    while (power_mode !== m && n < 50)
    begin
      @(posedge clock);
      n++;
    end
  endtask

  // enter a low power mode, try blocked wakes, then wake by source src
  task automatic pm_cycle(input logic [1:0] req, input int src, input logic [7:0] en);
    logic [1:0] r;
    logic [31:0] d;
    logic [2:0] m;
    int n;
    m = (req == BSP_REQ_IDLE) ? 3'h1 : ((req == BSP_REQ_SLEEP) ? 3'h3 : 3'h5);
    axi_wr(BSP_OFF_MODE_REQ, 32'(req), r);
    chk_resp(r, BSP_RESP_OKAY);
    // idle has no shutdown phase to wait through
    if (m != 3'h1) wait_mode(m - 3'h1, n);
    wait_mode(m, n);
    if (m != 3'h1) chk(32'(n), 32'(BSP_SHUT_CYCLES));
    chk(32'(power_mode), 32'(m));
    chk({30'h0, cpu_clk_en, sys_clk_en}, {30'h0, 1'b0, m != 3'h5});
    if (m == 3'h3) chk(32'(periph_clk_en & ~en), 32'h0);
    periph_irq <= ~en;
    watchdog_event <= (m == 3'h5);
    if (m != 3'h5)
    begin
      axi_wr(BSP_OFF_MODE_REQ, 32'(BSP_REQ_DEEP), r);
      axi_rd(BSP_OFF_MODE_STAT, d, r);
      chk(d, 32'(m));
    end
    repeat (4) @(posedge clock);
    chk(32'(power_mode), 32'(m));
    periph_irq <= (src == 2) ? en : 8'h00;
    watchdog_event <= (src == 0);
    nmi_req <= (src == 1);
    wake_req <= (src == 3);
    @(posedge clock);
    nmi_req <= 1'b0;
    wake_req <= 1'b0;
    watchdog_event <= 1'b0;
    wait_mode(3'h0, n);
    chk(32'(power_mode), 32'h0);
    periph_irq <= 8'h00;
  endtask

  // ==========================================
  // hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      summarize();
    end
  end

  // ==========================================
  // main sequence
  initial
  begin
    logic [34:0] e;
    logic [31:0] d, en;
    logic [1:0] r;
    logic [3:0] f;
    int n;
    do_reset(1'b0, 16);
    // every strap combination, after power-on and after software reset
    for (int k = 0; k < 128; k++)
    begin
      debug_enable_strap <= k[5];
      break_input_strap <= k[4];
      boot_cfg <= k[3:0];
      do_reset(k[6], 2);
      e = exp_boot(k[5], k[4], k[3:0], k[6]);
      f = FLG_TAB[e[34:32]*4 +: 4] | ((e[31:0] == BSP_PC_EMU) ? 4'h8 : 4'h0);
      chk(boot_pc, e[31:0]);
      chk(32'({cpu_run, ext_bus_enable, ext_bus_master, pins_tristate}), 32'(f));
      axi_rd(BSP_OFF_BOOT, d, r);
      chk(d, 32'(e[34:32]));
      debug_enable_strap <= ~k[5];
      break_input_strap <= ~k[4];
      boot_cfg <= ~k[3:0];
      repeat (3) @(posedge clock);
      chk(boot_pc, e[31:0]);
      if (e[34:32] == 3'h4)
      begin
        wait_mode(3'h5, n);
        chk(32'(power_mode), 32'h5);
      end
    end
    debug_enable_strap <= 1'b1;
    break_input_strap <= 1'b1;
    boot_cfg <= 4'h1;
    do_reset(1'b0, 2);
    for (int i = 0; i < 3; i++)
    begin
      axi_rd(BSP_OFF_SLEEP_EN + 8'(4 * i), d, r);
      // only the low NPER enable bits exist and read back
      chk(d, (i == 1) ? 32'(BSP_RST_CLK_EN[NPER-1:0]) : 32'h0000_0000);
    end
    axi_wr(8'h40, 32'h0000_0000, r);
    chk_resp(r, BSP_RESP_SLVERR);
    axi_rd(8'h40, d, r);
    chk_resp(r, BSP_RESP_SLVERR);
    chk(d, 32'h0000_0000);
    // request code zero is no mode change, the block stays in run
    axi_wr(BSP_OFF_MODE_REQ, 32'h0000_0000, r);
    chk_resp(r, BSP_RESP_OKAY);
    chk(32'(power_mode), 32'(BSP_PM_RUN));
    // automatic gating follows demand under the software enable mask
    seed = xs(seed);
    en = seed;
    axi_wr(BSP_OFF_CLK_EN, en, r);
    repeat (12)
    begin
      seed = xs(seed);
      periph_busy <= seed[7:0];
      repeat (2) @(posedge clock);
      chk(32'(periph_clk_en), 32'(en[7:0] & seed[7:0]));
      chk(32'(cpu_clk_en), 32'h1);
    end
    periph_busy <= 8'hFF;
    seed = xs(seed);
    en = (seed & 32'h0000_007E) | 32'h0000_0001;
    axi_wr(BSP_OFF_SLEEP_EN, en, r);
    axi_wr(BSP_OFF_WAKE_EN, en, r);
    for (int s = 0; s < 3; s++)
    begin
      pm_cycle(BSP_REQ_IDLE, s, en[7:0]);
      pm_cycle(BSP_REQ_SLEEP, s, en[7:0]);
    end
    pm_cycle(BSP_REQ_DEEP, 3, 8'h00);
    summarize();
  end
endmodule // test_boot_select_power_modes
